// File: key_model.sv
/* Keypad switch model on the port pins.
   Assumes switches fall back low when released. */
`timescale 1ns/1ps
module key_model (
    // Clock
    input wire logic clk_i,
    // Device drive
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    // Resolved pins
    output logic [7:0] pins_o
);
    logic [7:0] key = 8'h00;
    // Driven pins follow the device
    assign pins_o = (oe_i & out_i) | (~oe_i & key);
    task automatic press(input logic [7:0] m, input int n);
        key <= m;
        repeat (n) @(posedge clk_i);
        key <= 8'h00;
    endtask
endmodule

// File: pin_glitch_filter.sv
/*
 * One-pin glitch filter: the output follows the input only once the input
 * has held a new level for a selectable number of consecutive clocks.
 * Assumes the input is synchronous to clk_i.
 */
`timescale 1ns/1ps
module pin_glitch_filter
    import wake_port_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Pin and length select
    input wire logic pin_i,
    input wire logic long_i,
    input wire logic [CNT_W-1:0] long_len_i,
    // Filtered level
    output logic level_o
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] need;

    // Required stable length
    assign need = long_i ? long_len_i : CNT_W'(RUN_VALID_CLKS);

    // Count cycles of disagreement, accept when long enough
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count <= '0;
            level_o <= 1'b0;
        end else if (pin_i == level_o) begin
            count <= '0;
        end else if (count + CNT_W'(1) >= need) begin
            level_o <= pin_i;
            count <= '0;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

endmodule

// File: testbench.sv
/* Bench for wake_port: register bus, filters, flags.
   Assumes key_model drives the pins. */
`timescale 1ns/1ps
module testbench;
    import wake_port_pkg::*;
    logic clk_i = 0, srst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, rr, br;
    bit late_ans = 0;
    logic awready, wready, bvalid, arready, rvalid, irq_o, wake_o;
    logic [7:0] pins, pout, poe, drv, pen, pup, pwm = 8'h00;
    int num_errors = 0, n_tests = 0;
    wake_port DUT (.clk_i, .srst_i, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wake_port_pins_i(pins), .wake_port_pins_o(pout), .wake_port_pins_oe_o(poe),
        .reduced_drive_o(drv), .pull_enable_o(pen), .pull_up_o(pup), .pwm_i(pwm),
        .irq_o, .wake_o);
    key_model keys (.clk_i, .out_i(pout), .oe_i(poe), .pins_o(pins));
    // Clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= !late_ans;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk_i); while (!bvalid);
        // Late answer: response left waiting one cycle
        if (late_ans) begin
            bready <= 1;
            @(posedge clk_i);
        end
        br = bresp;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
        araddr <= a;
        arvalid <= 1;
        rready <= !late_ans;
        do @(posedge clk_i); while (!arready);
        arvalid <= 0;
        do @(posedge clk_i); while (!rvalid);
        if (late_ans) begin
            rready <= 1;
            @(posedge clk_i);
        end
        rr = rresp;
        chk(nm, rdata, {24'h0, e});
    endtask
    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    // Tests
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 0;
        @(posedge clk_i);
        for (int a = 0; a <= 8'h28; a += 4) rd(6'(a), 8'h00, "reset value");
        chk("oe", poe, 8'h00);
        rd(6'h2c, 8'h00, "unmapped");
        chk("unmapped resp", rr, RESP_SLVERR);
        wr(6'h2c, 8'hff);
        chk("unmapped wr resp", br, RESP_SLVERR);
        wr(OFS_SENSE, 8'hfd);
        chk("wr resp", br, RESP_OKAY);
        wr(OFS_IRQ_EN, 8'h01);
        keys.press(8'h01, 3);
        repeat (10) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h00, "short pulse");
        keys.press(8'h01, 4);
        repeat (10) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h01, "rising flag");
        chk("irq", irq_o, 1'b1);
        wr(OFS_IRQ_FLAG, 8'h00);
        rd(OFS_IRQ_FLAG, 8'h01, "zero write");
        wr(OFS_MODE, 8'h02);
        repeat (2) @(posedge clk_i);
        chk("wake wait", wake_o, 1'b1);
        wr(OFS_MODE, 8'h00);
        wr(OFS_IRQ_FLAG, 8'h01);
        rd(OFS_IRQ_FLAG, 8'h00, "clear");
        chk("irq clear", irq_o, 1'b0);
        keys.press(8'h02, 10);
        repeat (10) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h02, "falling flag");
        chk("masked", irq_o, 1'b0);
        wr(OFS_IRQ_EN, 8'h03);
        repeat (2) @(posedge clk_i);
        chk("shared irq", irq_o, 1'b1);
        wr(OFS_IRQ_FLAG, 8'h02);
        wr(OFS_DATA, 8'h04);
        wr(OFS_DIR, 8'h04);
        pwm <= 8'h08;
        wr(OFS_PWM_SEL, 8'h08);
        repeat (10) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h0c, "output edges");
        chk("pins out", pout, 8'h0c);
        chk("pins oe", poe, 8'h0c);
        rd(OFS_INPUT, 8'h0c, "pin input");
        wr(OFS_IRQ_FLAG, 8'h0c);
        late_ans = 1;
        wr(OFS_DRIVE, 8'ha5);
        late_ans = 0;
        wr(OFS_PULL_EN, 8'hff);
        wr(OFS_PULL_SEL, 8'h3c);
        repeat (2) @(posedge clk_i);
        chk("drive", drv, 8'ha5);
        chk("pull en", pen, 8'hfb);
        chk("pull up", pup, 8'h3c);
        late_ans = 1;
        rd(OFS_DRIVE, 8'ha5, "drive read");
        late_ans = 0;
        wr(OFS_MODE, 8'h01);
        keys.press(8'h01, 80);
        repeat (90) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h00, "stop short");
        keys.press(8'h01, 250);
        repeat (90) @(posedge clk_i);
        rd(OFS_IRQ_FLAG, 8'h01, "stop long");
        chk("wake stop", wake_o, 1'b1);
        // Reset in mid-run with pins driven and flags set
        srst_i <= 1;
        repeat (3) @(posedge clk_i);
        srst_i <= 0;
        @(posedge clk_i);
        chk("oe reset", poe, 8'h00);
        chk("wake reset", wake_o, 1'b0);
        rd(OFS_DIR, 8'h00, "dir reset");
        rd(OFS_IRQ_FLAG, 8'h00, "flag reset");
        complete_run();
    end
endmodule

// File: wake_port.sv
/*
 * Eight-pin general purpose port with per-pin filtered edge interrupts,
 * keypad wake-up, pin configuration and pulse-width modulator takeover.
 * Assumes synchronous pin inputs, one 25 MHz clock and an AXI4-Lite master
 * that keeps to the usual valid/ready rules.
 */
`timescale 1ns/1ps
module wake_port
    import wake_port_pkg::*;
#(
    parameter int N = PORT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // AXI4-Lite write address
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [N-1:0] wake_port_pins_i,
    output logic [N-1:0] wake_port_pins_o,
    output logic [N-1:0] wake_port_pins_oe_o,
    output logic [N-1:0] reduced_drive_o,
    output logic [N-1:0] pull_enable_o,
    output logic [N-1:0] pull_up_o,
    // Modulator outputs
    input wire logic [N-1:0] pwm_i,
    // Interrupt and wake
    output logic irq_o,
    output logic wake_o
);

    localparam int FW = 9;

    // Software registers
    logic [N-1:0] port_data;
    logic [N-1:0] dir;
    logic [N-1:0] drive;
    logic [N-1:0] pull_en;
    logic [N-1:0] pull_sel;
    logic [N-1:0] edge_sensitivity_select;
    logic [N-1:0] irq_en;
    logic [N-1:0] irq_flag;
    logic [N-1:0] pwm_sel;
    logic [1:0] mode;
    // Filter state and pin drive
    logic [N-1:0] filt;
    logic [N-1:0] filt_d;
    logic [N-1:0] edge_hit;
    logic [N-1:0] pin_out;
    // Bus state
    logic [5:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [N-1:0] wr_val;

    // Byte-lane merge of the low byte
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
        merge = s[0] ? d[7:0] : old;
    endfunction

    // Offset is mapped
    function automatic logic mapped(input logic [5:0] a);
        mapped = (a <= OFS_MODE) && (a[1:0] == 2'h0);
    endfunction

    // Write of one register offset this cycle
    function automatic logic wr_at(input logic go, input logic [5:0] a, input logic [5:0] ofs);
        wr_at = go && (a == ofs);
    endfunction

    // Per-pin glitch filters, long length while stopped
    for (genvar i = 0; i < N; i++) begin : g_filt
        pin_glitch_filter #(
            .CNT_W(FW)
        ) u_filt (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .pin_i(wake_port_pins_i[i]),
            .long_i(mode[MODE_STOP_BIT]),
            .long_len_i(FW'(STOP_FILT_CLKS)),
            .level_o(filt[i])
        );
    end

    // Previous filtered level
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            filt_d <= '0;
        end else begin
            filt_d <= filt;
        end
    end

    // Selected edge per pin, taken from pin level whatever the direction
    assign edge_hit = (filt & ~filt_d & edge_sensitivity_select) |
                      (~filt & filt_d & ~edge_sensitivity_select);

    // Write address and data latch, taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Write address holder; a new address cannot meet do_write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Write data holder
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Port data latch
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            port_data <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_DATA)) begin
            port_data <= merge(port_data, w_data, w_strb);
        end
    end

    // Direction, zero at reset so pins start as inputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dir <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_DIR)) begin
            dir <= merge(dir, w_data, w_strb);
        end
    end

    // Reduced drive select
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drive <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_DRIVE)) begin
            drive <= merge(drive, w_data, w_strb);
        end
    end

    // Pull device enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pull_en <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_PULL_EN)) begin
            pull_en <= merge(pull_en, w_data, w_strb);
        end
    end

    // Pull direction, one for up
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pull_sel <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_PULL_SEL)) begin
            pull_sel <= merge(pull_sel, w_data, w_strb);
        end
    end

    // Edge select, one for rising
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            edge_sensitivity_select <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_SENSE)) begin
            edge_sensitivity_select <= merge(edge_sensitivity_select, w_data, w_strb);
        end
    end

    // Interrupt enable per pin
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_en <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_IRQ_EN)) begin
            irq_en <= merge(irq_en, w_data, w_strb);
        end
    end

    // Modulator takeover per pin
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_sel <= RST_ZERO;
        end else if (wr_at(do_write, aw_addr, OFS_PWM_SEL)) begin
            pwm_sel <= merge(pwm_sel, w_data, w_strb);
        end
    end

    // Low-power mode, stands in for the processor state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode <= 2'h0;
        end else if (wr_at(do_write, aw_addr, OFS_MODE) && w_strb[0]) begin
            mode <= w_data[1:0];
        end
    end

    // Ones written to the flag register, per byte lane
    assign wr_val = (wr_at(do_write, aw_addr, OFS_IRQ_FLAG) && w_strb[0]) ? w_data[7:0] : '0;

    // Sticky flags: set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_flag <= RST_ZERO;
        end else begin
            irq_flag <= (irq_flag & ~wr_val) | edge_hit;
        end
    end

    // Single or-combined interrupt request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_flag & irq_en);
        end
    end

    // Wake request while a low-power mode is set
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= (|(irq_flag & irq_en)) && (|mode);
        end
    end

    // Pin drive: modulator or port data, enable from direction or modulator select
    assign pin_out = (pwm_sel & pwm_i) | (~pwm_sel & port_data);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_port_pins_o <= '0;
            wake_port_pins_oe_o <= '0;
        end else begin
            wake_port_pins_o <= pin_out;
            wake_port_pins_oe_o <= dir | pwm_sel;
        end
    end

    // Pad strength and pulls, pulls off on pins set as outputs in dir
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reduced_drive_o <= '0;
            pull_enable_o <= '0;
            pull_up_o <= '0;
        end else begin
            reduced_drive_o <= drive;
            pull_enable_o <= pull_en & ~dir;
            pull_up_o <= pull_sel;
        end
    end

    // Read channel, one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_DATA: s_axi_rdata <= {24'h0, port_data};
                OFS_DIR: s_axi_rdata <= {24'h0, dir};
                OFS_INPUT: s_axi_rdata <= {24'h0, wake_port_pins_i};
                OFS_DRIVE: s_axi_rdata <= {24'h0, drive};
                OFS_PULL_EN: s_axi_rdata <= {24'h0, pull_en};
                OFS_PULL_SEL: s_axi_rdata <= {24'h0, pull_sel};
                OFS_SENSE: s_axi_rdata <= {24'h0, edge_sensitivity_select};
                OFS_IRQ_EN: s_axi_rdata <= {24'h0, irq_en};
                OFS_IRQ_FLAG: s_axi_rdata <= {24'h0, irq_flag};
                OFS_PWM_SEL: s_axi_rdata <= {24'h0, pwm_sel};
                OFS_MODE: s_axi_rdata <= {30'h0, mode};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: wake_port_chk.sv
/* Port checker: reset state, bus handshakes, wake.
   Assumes it is bound to the wake_port top. */
`timescale 1ns/1ps
module wake_port_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Pins and interrupt
    input wire logic [7:0] wake_port_pins_o,
    input wire logic [7:0] wake_port_pins_oe_o,
    input wire logic irq_o,
    input wire logic wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Answer left waiting for the master
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    // Address and data taken at one edge
    sequence s_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_rst_oe;
        $past(srst_i) |-> wake_port_pins_oe_o == 8'h00;
    endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("oe set after reset");
    property p_rst_out;
        $past(srst_i) |-> wake_port_pins_o == 8'h00 && !irq_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("output set after reset");
    property p_r_hold;
        s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_hold;
        s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_b_answer;
        s_w_taken |=> ##1 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer late");
    property p_wake;
        wake_o |-> irq_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without request");
    // Request only drops after a write was answered
    property p_irq_drop;
        $fell(irq_o) |-> $past(s_axi_bvalid);
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("request dropped unasked");
endmodule
bind wake_port wake_port_chk u_chk (.clk_i, .srst_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .wake_port_pins_o, .wake_port_pins_oe_o, .irq_o, .wake_o);

// File: wake_port_pkg.sv
/*
 * Constants for the wake-up port block: register offsets, reset values
 * and glitch filter timing.
 * Assumes a 25 MHz bus clock and a 32-bit AXI4-Lite register bus.
 */
package wake_port_pkg;

    // Port width
    localparam int PORT_W = 8;

    // Register byte offsets
    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_DIR = 6'h04;
    localparam logic [5:0] OFS_INPUT = 6'h08;
    localparam logic [5:0] OFS_DRIVE = 6'h0c;
    localparam logic [5:0] OFS_PULL_EN = 6'h10;
    localparam logic [5:0] OFS_PULL_SEL = 6'h14;
    localparam logic [5:0] OFS_SENSE = 6'h18;
    localparam logic [5:0] OFS_IRQ_EN = 6'h1c;
    localparam logic [5:0] OFS_IRQ_FLAG = 6'h20;
    localparam logic [5:0] OFS_PWM_SEL = 6'h24;
    localparam logic [5:0] OFS_MODE = 6'h28;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Mode register field positions
    localparam int MODE_STOP_BIT = 0;
    localparam int MODE_WAIT_BIT = 1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_MHZ = 25;
    localparam int RUN_IGNORE_CLKS = 3;
    localparam int RUN_VALID_CLKS = 4;
    localparam real STOP_IGNORE_US = 3.2;
    localparam real STOP_VALID_US = 10.0;
    // Stop filter length: at least the ignore time, at most the valid time
    localparam int STOP_FILT_CLKS = int'($ceil(STOP_IGNORE_US * CLK_MHZ)) + 1;
    localparam int STOP_MAX_CLKS = int'($floor(STOP_VALID_US * CLK_MHZ));

endpackage
